// File: src/bcdudc_pkg.sv
// Constants and carrier types of the BCD up/down decade counter
package bcdudc_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int CNT_W  = 4;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int WRAP_W = 16;
  localparam int CTL_W  = 8;
  localparam int STAT_W = 8;

  // ************************************************************
  // Decade limits, 8421 weighting
  // ************************************************************
  localparam logic [CNT_W-1:0] BCD_TOP = 4'h9;
  localparam logic [CNT_W-1:0] BCD_BOT = 4'h0;
  localparam logic [CNT_W-1:0] BCD_ONE = 4'h1;

  // ************************************************************
  // Register map (byte addresses) and fields
  // ************************************************************
  localparam logic [APB_AW-1:0] CTRL_OFF   = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFF = 12'h004;
  localparam logic [APB_AW-1:0] WRAPS_OFF  = 12'h008;
  localparam int                CTRL_MODE_BIT = 8;
  localparam logic [CTL_W-1:0]  CTRL_CTL_RST  = 8'h50;
  localparam logic              CTRL_MODE_RST = 1'h0;
  localparam logic [WRAP_W-1:0] WRAPS_RST     = 16'h0000;
  localparam logic [WRAP_W-1:0] WRAPS_ONE     = 16'h0001;
  localparam logic [APB_DW-1:0] RDATA_RST     = 32'h0000_0000;

  // ************************************************************
  // Carrier types
  // ************************************************************
  // Counter controls, also the low byte of the control register
  typedef struct packed {
    logic             clk;
    logic             ce_n;
    logic             dir_dn;
    logic             load_n;
    logic [CNT_W-1:0] preset;
  } bcdudc_ctl_type;

  typedef struct packed {
    logic             load_act;
    logic             dir_dn;
    logic             rc_n;
    logic             tc;
    logic [CNT_W-1:0] count;
  } bcdudc_stat_type;

  typedef enum logic [1:0] {
    REG_CTRL,
    REG_STAT,
    REG_WRAPS,
    REG_NONE
  } bcdudc_reg_type;

  typedef struct packed {
    logic meta;
    logic sync;
  } bcdudc_rst_state_type;

  typedef struct packed {
    logic [CNT_W-1:0]  count;
    logic              clk_prev;
    logic              rc_n;
    logic              mode;
    bcdudc_ctl_type    sw;
    logic [WRAP_W-1:0] wraps;
    logic [APB_DW-1:0] prdata;
  } bcdudc_top_state_type;

  // One decade step; a code above nine goes up to zero, down to nine
  function automatic logic [CNT_W-1:0] bcd_step(
    input logic [CNT_W-1:0] cur,
    input logic             dn
  );
    logic [CNT_W-1:0] nxt;
    nxt = cur;
    if (!dn) begin
      nxt = (cur >= BCD_TOP) ? BCD_BOT : CNT_W'(cur + BCD_ONE);
    end else begin
      nxt = (cur == BCD_BOT || cur > BCD_TOP) ? BCD_TOP
                                              : CNT_W'(cur - BCD_ONE);
    end
    return nxt;
  endfunction : bcd_step

endpackage : bcdudc_pkg

// File: src/bcdudc_rst_sync.sv
// Reset release synchroniser for the decade counter
`timescale 1ns/10ps
module bcdudc_rst_sync (
  // Clock and raw reset
  input  wire logic clk,
  input  wire logic rst_n_in,
  // Released copy
  output logic      rst_n_out
);

  bcdudc_pkg::bcdudc_rst_state_type st_reg;
  bcdudc_pkg::bcdudc_rst_state_type st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = 1'h1;
    st_next.sync = st_reg.meta;
  end

  // Assert at once, release two edges later
  always_ff @(posedge clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rst_n_out = st_reg.sync;

endmodule : bcdudc_rst_sync

// File: src/bcdudc_apb_dec.sv
// APB slave handshake and address decode for the decade counter
`timescale 1ns/10ps
module bcdudc_apb_dec (
  // APB request
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [bcdudc_pkg::APB_AW-1:0] paddr,
  // APB answer
  output logic                               pready,
  output logic                               pslverr,
  // Register side strobes
  output logic                               wr_stb,
  output logic                               rd_setup,
  output bcdudc_pkg::bcdudc_reg_type         reg_sel
);

  // Zero wait: read data is captured in the setup cycle
  always_comb begin
    unique case (paddr)
      bcdudc_pkg::CTRL_OFF:   reg_sel = bcdudc_pkg::REG_CTRL;
      bcdudc_pkg::STATUS_OFF: reg_sel = bcdudc_pkg::REG_STAT;
      bcdudc_pkg::WRAPS_OFF:  reg_sel = bcdudc_pkg::REG_WRAPS;
      default:                reg_sel = bcdudc_pkg::REG_NONE;
    endcase
  end

  assign pready   = psel && penable;
  assign pslverr  = pready && (reg_sel == bcdudc_pkg::REG_NONE);
  assign wr_stb   = pready && pwrite && !pslverr;
  assign rd_setup = psel && !penable && !pwrite;

endmodule : bcdudc_apb_dec

// File: src/bcdudc_top.sv
// BCD up/down decade counter with preset, terminal count and ripple clock
//
// Notes on behaviour
// - Load low shows preset at once
// - Load overrides enable, direction and clock
// - Enable high holds the count
// - Enabled count changes on clock rise only
// - Direction low counts up, high down
// - Terminal flag at nine up, zero down
// - Flag holds until state or direction changes
// - Ripple output rests high unless enabled
// - Ripple low in clock low phase
// - Terminal condition gates the ripple pulse
// - Count uses 8421 BCD weighting
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module bcdudc_top (
  // Clock and reset
  input  wire logic                          CORE_CLK,
  input  wire logic                          RST_N,
  // APB slave
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [bcdudc_pkg::APB_AW-1:0] PADDR,
  input  wire logic [bcdudc_pkg::APB_DW-1:0] PWDATA,
  output logic      [bcdudc_pkg::APB_DW-1:0] PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // Counter pins
  input  wire logic                          COUNT_CLOCK,
  input  wire logic                          COUNT_ENABLE_N,
  input  wire logic                          DIR_DOWN,
  input  wire logic                          LOAD_STROBE_N,
  input  wire logic [bcdudc_pkg::CNT_W-1:0]  PRESET_INPUTS,
  output logic      [bcdudc_pkg::CNT_W-1:0]  COUNT_OUTPUTS,
  output logic                               TERMINAL_COUNT_FLAG,
  output logic                               RIPPLE_CLOCK_N
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic                              rst_n;
  logic                              wr_stb;
  logic                              rd_setup;
  bcdudc_pkg::bcdudc_reg_type        reg_sel;
  bcdudc_pkg::bcdudc_top_state_type  st_reg;
  bcdudc_pkg::bcdudc_top_state_type  st_next;
  bcdudc_pkg::bcdudc_ctl_type        pin_ctl;
  bcdudc_pkg::bcdudc_ctl_type        ctl;
  bcdudc_pkg::bcdudc_stat_type       stat;
  logic                              load_act;
  logic [bcdudc_pkg::CNT_W-1:0]      shown;
  logic                              tc;
  logic                              rise;
  logic                              step;
  logic                              wrap_evt;
  logic                              wraps_clr;

  // ************************************************************
  // Reset release and bus decode
  // ************************************************************
  bcdudc_rst_sync u_rst (
    .clk       (CORE_CLK),
    .rst_n_in  (RST_N),
    .rst_n_out (rst_n)
  );

  bcdudc_apb_dec u_apb (
    .psel     (PSEL),
    .penable  (PENABLE),
    .pwrite   (PWRITE),
    .paddr    (PADDR),
    .pready   (PREADY),
    .pslverr  (PSLVERR),
    .wr_stb   (wr_stb),
    .rd_setup (rd_setup),
    .reg_sel  (reg_sel)
  );

  // ************************************************************
  // Control source
  // ************************************************************
  // Pins are sampled on the core clock, so the far end keeps them
  // steady around each core edge as it would around the count edge
  assign pin_ctl.clk    = COUNT_CLOCK;
  assign pin_ctl.ce_n   = COUNT_ENABLE_N;
  assign pin_ctl.dir_dn = DIR_DOWN;
  assign pin_ctl.load_n = LOAD_STROBE_N;
  assign pin_ctl.preset = PRESET_INPUTS;

  // Software mode lets a host drive the counter with no pins wired
  assign ctl = st_reg.mode ? st_reg.sw : pin_ctl;

  // ************************************************************
  // Counter decode
  // ************************************************************
  assign load_act = !ctl.load_n;
  // Load bypasses the flops so the preset shows without any edge
  assign shown    = load_act ? ctl.preset : st_reg.count;

  // Pure decode of shown value and direction: it stays high until
  // either of them moves, and may spike while they settle
  assign tc = (!ctl.dir_dn && (shown == bcdudc_pkg::BCD_TOP)) ||
              (ctl.dir_dn && (shown == bcdudc_pkg::BCD_BOT));

  assign rise     = ctl.clk && !st_reg.clk_prev;
  assign step     = !load_act && !ctl.ce_n && rise;
  assign wrap_evt = step && tc;
  assign wraps_clr = wr_stb && (reg_sel == bcdudc_pkg::REG_WRAPS);

  assign stat.load_act = load_act;
  assign stat.dir_dn   = ctl.dir_dn;
  assign stat.rc_n     = st_reg.rc_n;
  assign stat.tc       = tc;
  assign stat.count    = shown;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_next          = st_reg;
    // Tracked through loads too, so release never fakes an edge
    st_next.clk_prev = ctl.clk;

    if (load_act) begin
      st_next.count = ctl.preset;
    end else if (step) begin
      st_next.count = bcdudc_pkg::bcd_step(st_reg.count,
                                           ctl.dir_dn);
    end

    // Low only while enabled, at terminal, with the clock low
    st_next.rc_n = !(!ctl.ce_n && tc && !ctl.clk);

    // A wrap in the clearing cycle is kept as one
    if (wraps_clr) begin
      st_next.wraps = wrap_evt ? bcdudc_pkg::WRAPS_ONE
                               : bcdudc_pkg::WRAPS_RST;
    end else if (wrap_evt) begin
      st_next.wraps = bcdudc_pkg::WRAP_W'(st_reg.wraps +
                                          bcdudc_pkg::WRAPS_ONE);
    end

    if (wr_stb && (reg_sel == bcdudc_pkg::REG_CTRL)) begin
      st_next.mode = PWDATA[bcdudc_pkg::CTRL_MODE_BIT];
      st_next.sw   = PWDATA[bcdudc_pkg::CTL_W-1:0];
    end

    if (rd_setup) begin
      st_next.prdata = bcdudc_pkg::RDATA_RST;
      unique case (reg_sel)
        bcdudc_pkg::REG_CTRL: begin
          st_next.prdata[bcdudc_pkg::CTRL_MODE_BIT] = st_reg.mode;
          st_next.prdata[bcdudc_pkg::CTL_W-1:0]     = st_reg.sw;
        end
        bcdudc_pkg::REG_STAT: begin
          st_next.prdata[bcdudc_pkg::STAT_W-1:0] = stat;
        end
        bcdudc_pkg::REG_WRAPS: begin
          st_next.prdata[bcdudc_pkg::WRAP_W-1:0] = st_reg.wraps;
        end
        bcdudc_pkg::REG_NONE: begin
          st_next.prdata = bcdudc_pkg::RDATA_RST;
        end
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.count    <= bcdudc_pkg::BCD_BOT;
      st_reg.clk_prev <= 1'h0;
      st_reg.rc_n     <= 1'h1;
      st_reg.mode     <= bcdudc_pkg::CTRL_MODE_RST;
      st_reg.sw       <= bcdudc_pkg::CTRL_CTL_RST;
      st_reg.wraps    <= bcdudc_pkg::WRAPS_RST;
      st_reg.prdata   <= bcdudc_pkg::RDATA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign COUNT_OUTPUTS       = shown;
  assign TERMINAL_COUNT_FLAG = tc;
  assign RIPPLE_CLOCK_N      = st_reg.rc_n;
  assign PRDATA              = st_reg.prdata;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_load_shows_preset: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    !ctl.load_n |-> COUNT_OUTPUTS == ctl.preset)
    else $error("load does not show preset at once");

  a_load_keeps_preset: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (!ctl.load_n && !ctl.ce_n && rise)
      |=> st_reg.count == $past(ctl.preset))
    else $error("counting acted during load");

  a_hold_disabled: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (ctl.load_n && ctl.ce_n)[*2] |-> $stable(COUNT_OUTPUTS))
    else $error("count moved while disabled");

  a_no_edge_hold: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (ctl.load_n && !rise) ##1 ctl.load_n
      |-> $stable(COUNT_OUTPUTS))
    else $error("count moved without a clock rise");

  a_up_one_step: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (step && !ctl.dir_dn && st_reg.count < bcdudc_pkg::BCD_TOP)
      ##1 ctl.load_n
      |-> COUNT_OUTPUTS == $past(st_reg.count) + bcdudc_pkg::BCD_ONE)
    else $error("up count not one more");

  a_down_one_step: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (step && ctl.dir_dn && st_reg.count != bcdudc_pkg::BCD_BOT &&
     st_reg.count <= bcdudc_pkg::BCD_TOP) ##1 ctl.load_n
      |-> COUNT_OUTPUTS == $past(st_reg.count) - bcdudc_pkg::BCD_ONE)
    else $error("down count not one less");

  a_wrap_up: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (step && !ctl.dir_dn && st_reg.count == bcdudc_pkg::BCD_TOP)
      |=> st_reg.count == bcdudc_pkg::BCD_BOT)
    else $error("nine up did not wrap to zero");

  a_wrap_down: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (step && ctl.dir_dn && st_reg.count == bcdudc_pkg::BCD_BOT)
      |=> st_reg.count == bcdudc_pkg::BCD_TOP)
    else $error("zero down did not wrap to nine");

  a_tc_mid_low: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (COUNT_OUTPUTS > bcdudc_pkg::BCD_BOT &&
     COUNT_OUTPUTS < bcdudc_pkg::BCD_TOP) |-> !TERMINAL_COUNT_FLAG)
    else $error("terminal flag high mid decade");

  a_tc_holds: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (TERMINAL_COUNT_FLAG ##1 ($stable(COUNT_OUTPUTS) &&
                              $stable(ctl.dir_dn)))
      |-> TERMINAL_COUNT_FLAG)
    else $error("terminal flag dropped with no change");

  a_rc_rests_high: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (ctl.ce_n || !TERMINAL_COUNT_FLAG) |=> RIPPLE_CLOCK_N)
    else $error("ripple output low while not enabled");

  a_rc_pulse: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (!ctl.ce_n && TERMINAL_COUNT_FLAG && !ctl.clk)
      |=> !RIPPLE_CLOCK_N)
    else $error("ripple pulse shape wrong");

  a_bcd_stays_valid: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (step && st_reg.count <= bcdudc_pkg::BCD_TOP)
      |=> st_reg.count <= bcdudc_pkg::BCD_TOP)
    else $error("count left the decade");

  a_apb_answer: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> PREADY)
    else $error("access phase not answered at once");

  a_rc_back_high: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    ctl.clk |=> RIPPLE_CLOCK_N)
    else $error("ripple output not high after clock rise");

  a_tc_up_nine: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (!ctl.dir_dn && COUNT_OUTPUTS == bcdudc_pkg::BCD_TOP)
      |-> TERMINAL_COUNT_FLAG)
    else $error("terminal flag low at nine counting up");

  a_tc_down_zero: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (ctl.dir_dn && COUNT_OUTPUTS == bcdudc_pkg::BCD_BOT)
      |-> TERMINAL_COUNT_FLAG)
    else $error("terminal flag low at zero counting down");

  a_tc_up_zero_low: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (!ctl.dir_dn && COUNT_OUTPUTS == bcdudc_pkg::BCD_BOT)
      |-> !TERMINAL_COUNT_FLAG)
    else $error("terminal flag high at zero counting up");

  a_dir_flips_tc: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (COUNT_OUTPUTS == bcdudc_pkg::BCD_BOT && $stable(COUNT_OUTPUTS) &&
     $changed(ctl.dir_dn)) |-> $changed(TERMINAL_COUNT_FLAG))
    else $error("direction change left terminal flag alone");

  a_load_sets_flop: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    !ctl.load_n |=> st_reg.count == $past(ctl.preset))
    else $error("load did not reach the count flops");

  a_enabled_moves: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (step ##1 ctl.load_n) |-> $changed(COUNT_OUTPUTS))
    else $error("enabled clock rise left count alone");

  a_ripple_needs_tc: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    !RIPPLE_CLOCK_N |-> $past(TERMINAL_COUNT_FLAG) && !$past(ctl.ce_n))
    else $error("ripple pulse without terminal count");

  a_wraps_tally: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (wrap_evt && !wraps_clr) |=>
      st_reg.wraps == $past(st_reg.wraps) + bcdudc_pkg::WRAPS_ONE)
    else $error("wrap counter did not advance");

  a_wraps_cleared: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (wraps_clr && !wrap_evt) |=> st_reg.wraps == bcdudc_pkg::WRAPS_RST)
    else $error("wrap counter not cleared by write");

  a_ctrl_mode_write: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (wr_stb && reg_sel == bcdudc_pkg::REG_CTRL) |=>
      st_reg.mode == $past(PWDATA[bcdudc_pkg::CTRL_MODE_BIT]))
    else $error("control write did not set the mode");

  a_unmapped_reads_zero: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    (rd_setup && reg_sel == bcdudc_pkg::REG_NONE) |=>
      PRDATA == bcdudc_pkg::RDATA_RST)
    else $error("unmapped read returned data");

endmodule : bcdudc_top

// File: verif/bcdudc_pins_model.sv
// Pin-side partner: control logic driving the counter's pins
`timescale 1ns/10ps
module bcdudc_pins_model (
  // Core clock only; the terminal flag is never taken as a clock here
  input  wire logic                         core_clk,
  // Counter controls
  output logic                              count_clock,
  output logic                              ce_n,
  output logic                              dir_dn,
  output logic                              load_n,
  output logic [bcdudc_pkg::CNT_W-1:0]      preset
);

  initial begin
    count_clock = 1'b0;
    ce_n        = 1'b1;
    dir_dn      = 1'b0;
    load_n      = 1'b1;
    preset      = 4'h0;
  end

  // ************************************************************
  // Control changes, made only while the count clock is low
  // ************************************************************
  task automatic set_ctl(input logic ce, input logic dn, input logic ld,
                         input logic [bcdudc_pkg::CNT_W-1:0] val);
    @(posedge core_clk);
    ce_n   <= ce;
    dir_dn <= dn;
    load_n <= ld;
    preset <= val;
  endtask : set_ctl

  // Each phase lasts two core cycles so the sampled edge is never lost
  task automatic step();
    @(posedge core_clk);
    count_clock <= 1'b1;
    repeat (2) @(posedge core_clk);
    count_clock <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : step

endmodule : bcdudc_pins_model

// File: verif/bcdudc_bench.sv
// Self-checking bench for the BCD up/down decade counter
`timescale 1ns/10ps
module bcdudc_bench;
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        count_clock;
  logic        ce_n;
  logic        dir_dn;
  logic        load_n;
  logic [3:0]  preset;
  logic [3:0]  count;
  logic        tc;
  logic        rc_n;
  logic [3:0]  exp;
  logic        dn;
  logic        ce;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          checks;

  bcdudc_top bcdudc_top_inst (
    .CORE_CLK            (core_clk),
    .RST_N               (rst_n),
    .PSEL                (psel),
    .PENABLE             (penable),
    .PWRITE              (pwrite),
    .PADDR               (paddr),
    .PWDATA              (pwdata),
    .PRDATA              (prdata),
    .PREADY              (pready),
    .PSLVERR             (pslverr),
    .COUNT_CLOCK         (count_clock),
    .COUNT_ENABLE_N      (ce_n),
    .DIR_DOWN            (dir_dn),
    .LOAD_STROBE_N       (load_n),
    .PRESET_INPUTS       (preset),
    .COUNT_OUTPUTS       (count),
    .TERMINAL_COUNT_FLAG (tc),
    .RIPPLE_CLOCK_N      (rc_n)
  );

  bcdudc_pins_model bcdudc_pins_model_inst (
    .core_clk    (core_clk),
    .count_clock (count_clock),
    .ce_n        (ce_n),
    .dir_dn      (dir_dn),
    .load_n      (load_n),
    .preset      (preset)
  );

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // ************************************************************
  // Comparison, verdict and bus tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] expv);
    checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, expv, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] expv, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, expv);
    check("slave error", 32'(err), 32'(experr));
  endtask : rdchk

  function automatic logic [3:0] nxt(input logic [3:0] v, input logic d);
    if (d) return (v == 4'h0) ? 4'h9 : v - 4'h1;
    return (v == 4'h9) ? 4'h0 : v + 4'h1;
  endfunction : nxt

  // Pins looked at mid-cycle, well clear of any clock edge
  task automatic pins();
    logic tcx;
    tcx = dn ? (exp == 4'h0) : (exp == 4'h9);
    @(negedge core_clk);
    check("count", 32'(count), 32'(exp));
    check("terminal flag", 32'(tc), 32'(tcx));
    check("ripple", 32'(rc_n), 32'(ce | !tcx));
  endtask : pins

  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      bcdudc_pins_model_inst.step();
      exp = ce ? exp : nxt(exp, dn);
      pins();
    end
  endtask : run

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    checks = 0;
    exp = 4'h0;
    dn = 1'b0;
    ce = 1'b1;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    pins();
    rdchk("ctrl", bcdudc_pkg::CTRL_OFF, 32'h0000_0050, 1'b0);
    rdchk("status", bcdudc_pkg::STATUS_OFF, 32'h0000_0020, 1'b0);
    rdchk("wraps", bcdudc_pkg::WRAPS_OFF, 32'h0000_0000, 1'b0);
    $display("test reset done");
    ce = 1'b0;
    exp = 4'h7;
    bcdudc_pins_model_inst.set_ctl(1'b0, 1'b0, 1'b0, 4'h7);
    pins();
    bcdudc_pins_model_inst.step();
    pins();
    bcdudc_pins_model_inst.set_ctl(1'b0, 1'b0, 1'b1, 4'h7);
    $display("test load done");
    run(3);
    dn = 1'b1;
    bcdudc_pins_model_inst.set_ctl(1'b0, 1'b1, 1'b1, 4'h7);
    repeat (2) @(posedge core_clk);
    pins();
    run(2);
    rdchk("wraps", bcdudc_pkg::WRAPS_OFF, 32'h0000_0002, 1'b0);
    apb(1'b1, bcdudc_pkg::WRAPS_OFF, 32'h0000_0000);
    rdchk("wraps", bcdudc_pkg::WRAPS_OFF, 32'h0000_0000, 1'b0);
    $display("test count done");
    ce = 1'b1;
    exp = 4'h0;
    bcdudc_pins_model_inst.set_ctl(1'b1, 1'b1, 1'b0, 4'h0);
    pins();
    bcdudc_pins_model_inst.set_ctl(1'b1, 1'b1, 1'b1, 4'h0);
    run(2);
    $display("test hold done");
    apb(1'b1, bcdudc_pkg::CTRL_OFF, 32'h0000_0103);
    rdchk("status", bcdudc_pkg::STATUS_OFF, 32'h0000_00A3, 1'b0);
    apb(1'b1, bcdudc_pkg::CTRL_OFF, 32'h0000_0113);
    apb(1'b1, bcdudc_pkg::CTRL_OFF, 32'h0000_0193);
    repeat (3) @(posedge core_clk);
    rdchk("status", bcdudc_pkg::STATUS_OFF, 32'h0000_0024, 1'b0);
    apb(1'b1, bcdudc_pkg::CTRL_OFF, 32'h0000_0010);
    exp = 4'h4;
    pins();
    rdchk("unmapped", 12'h00C, 32'h0000_0000, 1'b1);
    $display("test registers done");
    give_verdict();
  end

endmodule : bcdudc_bench
